// [logic/csu_pkg.sv]
/*
 * Package for the shift execution unit: opcode patterns, field positions,
 * widths and reset values shared by the unit and its register file.
 * Assumes a 16-bit instruction word and sixteen 32-bit general registers.
 */
`default_nettype none

package csu_pkg;
	localparam int unsigned CSU_DATA_W = 32;
	localparam int unsigned CSU_IR_W = 16;
	localparam int unsigned CSU_REG_AW = 4;
	localparam int unsigned CSU_REG_COUNT = 16;
	localparam int unsigned CSU_PC_W = 32;
	localparam int unsigned CSU_CNT_W = 5;

	// Instruction fields
	localparam int unsigned CSU_OP_HI_POS = 12;
	localparam int unsigned CSU_DST_POS = 8;
	localparam int unsigned CSU_SRC_POS = 4;

	// Group nibble and low-byte opcodes of the one-operand shifts
	localparam logic [3:0] CSU_GROUP = 4'h4;
	localparam logic [7:0] CSU_OP_LEFT_ONE = 8'h00;
	localparam logic [7:0] CSU_OP_RIGHT_ONE = 8'h01;
	localparam logic [7:0] CSU_OP_ARITH_RIGHT_ONE = 8'h21;
	localparam logic [7:0] CSU_OP_LEFT_TWO = 8'h08;
	localparam logic [7:0] CSU_OP_LEFT_EIGHT = 8'h18;
	localparam logic [7:0] CSU_OP_LEFT_SIXTEEN = 8'h28;
	localparam logic [7:0] CSU_OP_RIGHT_TWO = 8'h09;
	localparam logic [7:0] CSU_OP_RIGHT_EIGHT = 8'h19;
	localparam logic [7:0] CSU_OP_RIGHT_SIXTEEN = 8'h29;
	// Dynamic shift: low nibble only
	localparam logic [3:0] CSU_OP_DYNAMIC = 4'hd;

	// Fixed distances
	localparam logic [CSU_CNT_W-1:0] CSU_DIST_TWO = 5'h02;
	localparam logic [CSU_CNT_W-1:0] CSU_DIST_EIGHT = 5'h08;
	localparam logic [CSU_CNT_W-1:0] CSU_DIST_SIXTEEN = 5'h10;

	// Program counter step per instruction, in bytes
	localparam logic [CSU_PC_W-1:0] CSU_PC_STEP = 32'h00000002;
	localparam logic [CSU_PC_W-1:0] CSU_PC_RESET = 32'h00000000;
	localparam logic [CSU_DATA_W-1:0] CSU_REG_RESET = 32'h00000000;
	localparam logic CSU_FLAG_RESET = 1'b0;

	typedef enum logic [3:0] {
		CSU_NONE,
		CSU_ARITH_RIGHT_ONE,
		CSU_LEFT_ONE,
		CSU_RIGHT_ONE,
		CSU_LEFT_FIXED,
		CSU_RIGHT_FIXED,
		CSU_DYNAMIC
	} csu_kind_e;
endpackage : csu_pkg

`default_nettype wire

// [logic/csu_regfile.sv]
/*
 * General register file: one write port, two read ports, read data
 * registered. Assumes the caller issues the read one cycle before use.
 */
`default_nettype none

module csu_regfile
	import csu_pkg::*;
#(
	parameter int unsigned DATA_W = CSU_DATA_W,
	parameter int unsigned ADDR_W = CSU_REG_AW
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] rd_a_addr,
	input wire logic [ADDR_W-1:0] rd_b_addr,
	output logic [DATA_W-1:0] rd_a_data,
	output logic [DATA_W-1:0] rd_b_data,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data
);
	logic [DATA_W-1:0] mem [2**ADDR_W];

	// Storage; reset clears so simulation starts from known values
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 2**ADDR_W; i++)
				mem[i] <= CSU_REG_RESET;
		end
		else if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Registered reads, old data on a same-cycle write
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rd_a_data <= CSU_REG_RESET;
			rd_b_data <= CSU_REG_RESET;
		end
		else if (ce)
		begin
			rd_a_data <= mem[rd_a_addr];
			rd_b_data <= mem[rd_b_addr];
		end
	end
endmodule // csu_regfile

`default_nettype wire

// [logic/csu_shift_unit.sv]
/*
 * Shift execution unit: decodes one 16-bit shift instruction at a time,
 * reads the general registers, shifts, writes back and steps the PC.
 * Assumes the fetch side holds instr stable with instr_valid until
 * instr_ready answers; instructions outside the group are refused.
 * The rest of the core fills registers through the load port, which
 * is honoured only while the unit idles; a load offered at any other
 * time is dropped, so the core waits for instr_ready before loading.
 * Outside loads are not mirrored on the write-back port.
 */
`default_nettype none

// Notes on behaviour
// - One-bit arithmetic right shift keeps the sign bit, writes back to same register.
// - One-bit shifts put the pushed-out bit in the flag: low for right, high for left.
// - One-bit logical left shift inserts zero at bit 0, writes back.
// - One-bit logical right shift clears the top bit, writes back.
// - Dynamic shift goes left for non-negative count register, right for negative.
// - Dynamic right shift fills vacated upper bits with zeros.
// - Dynamic shift amount comes only from the five low count bits.
// - Negative count is two's complement; right distance is 32 minus the five low count bits.
// - Left distance 0 to 31, right 1 to 32; right by 32 clears.
// - Fixed left shifts by two, eight or sixteen fill low bits with zeros.
// - Fixed right shifts by two, eight or sixteen fill high bits with zeros.
// - Multi-bit and dynamic shifts drop outside bits and leave the flag alone.
module csu_shift_unit
	import csu_pkg::*;
#(
	parameter int unsigned DATA_W = CSU_DATA_W
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic instr_valid,
	input wire logic [CSU_IR_W-1:0] instr,
	input wire logic load_en,
	input wire logic [CSU_REG_AW-1:0] load_addr,
	input wire logic [DATA_W-1:0] load_data,
	output logic instr_ready,
	output logic instr_illegal,
	output logic [CSU_PC_W-1:0] pc,
	output logic t_flag,
	output logic wb_valid,
	output logic [CSU_REG_AW-1:0] wb_addr,
	output logic [DATA_W-1:0] wb_data
);
	// Idle, register read, then the single execution state
	typedef enum logic [1:0] {
		CSU_IDLE,
		CSU_READ,
		CSU_EXEC
	} csu_state_e;

	// Latched instruction fields, decode results and datapath nets
	csu_state_e state_reg;
	csu_kind_e kind_reg;
	logic [CSU_CNT_W-1:0] fixed_dist_reg;
	logic [CSU_REG_AW-1:0] dst_reg;
	logic [CSU_REG_AW-1:0] src_reg;
	csu_kind_e kind_next;
	logic [CSU_CNT_W-1:0] fixed_dist_next;
	logic [DATA_W-1:0] opnd;
	logic [DATA_W-1:0] cnt;
	logic [DATA_W-1:0] result;
	logic flag_next;
	logic flag_write;
	logic rf_wr;
	// Handshake qualifiers
	logic legal;
	logic take;
	// Register file write port after the load mux
	logic rf_we;
	logic [CSU_REG_AW-1:0] rf_waddr;
	logic [DATA_W-1:0] rf_wdata;

	// Instruction decode to shift kind and fixed distance
	always_comb
	begin
		kind_next = CSU_NONE;
		fixed_dist_next = CSU_DIST_TWO;
		if (instr[CSU_IR_W-1:CSU_OP_HI_POS] == CSU_GROUP)
		begin
			if (instr[3:0] == CSU_OP_DYNAMIC)
				kind_next = CSU_DYNAMIC;
			else
			begin
				case (instr[7:0])
					CSU_OP_ARITH_RIGHT_ONE: kind_next = CSU_ARITH_RIGHT_ONE;
					CSU_OP_LEFT_ONE: kind_next = CSU_LEFT_ONE;
					CSU_OP_RIGHT_ONE: kind_next = CSU_RIGHT_ONE;
					CSU_OP_LEFT_TWO: kind_next = CSU_LEFT_FIXED;
					CSU_OP_LEFT_EIGHT:
					begin
						kind_next = CSU_LEFT_FIXED;
						fixed_dist_next = CSU_DIST_EIGHT;
					end
					CSU_OP_LEFT_SIXTEEN:
					begin
						kind_next = CSU_LEFT_FIXED;
						fixed_dist_next = CSU_DIST_SIXTEEN;
					end
					CSU_OP_RIGHT_TWO: kind_next = CSU_RIGHT_FIXED;
					CSU_OP_RIGHT_EIGHT:
					begin
						kind_next = CSU_RIGHT_FIXED;
						fixed_dist_next = CSU_DIST_EIGHT;
					end
					CSU_OP_RIGHT_SIXTEEN:
					begin
						kind_next = CSU_RIGHT_FIXED;
						fixed_dist_next = CSU_DIST_SIXTEEN;
					end
					default: kind_next = CSU_NONE;
				endcase
			end
		end
	end

	// One word per handshake; a word outside the group is consumed and refused
	assign legal = kind_next != CSU_NONE;
	assign take = state_reg == CSU_IDLE && instr_valid && instr_ready;

	// Dynamic logical shift; a 33-bit right path gives the distance of 32
	function automatic logic [DATA_W-1:0] dyn_shift(input logic [DATA_W-1:0] v,
		input logic [DATA_W-1:0] c);
		logic [CSU_CNT_W-1:0] amt;
		logic [CSU_CNT_W:0] rdist;
		logic [DATA_W:0] wide;
		amt = c[CSU_CNT_W-1:0];
		rdist = {1'b0, ~amt} + {{CSU_CNT_W{1'b0}}, 1'b1};
		wide = {1'b0, v} >> rdist;
		if (!c[DATA_W-1])
			dyn_shift = v << amt;
		else
			dyn_shift = wide[DATA_W-1:0];
	endfunction

	// Datapath for the instruction in its execution state
	always_comb
	begin
		result = opnd;
		flag_next = t_flag;
		flag_write = 1'b0;
		case (kind_reg)
			CSU_ARITH_RIGHT_ONE:
			begin
				result = {opnd[DATA_W-1], opnd[DATA_W-1:1]};
				flag_next = opnd[0];
				flag_write = 1'b1;
			end
			CSU_LEFT_ONE:
			begin
				result = {opnd[DATA_W-2:0], 1'b0};
				flag_next = opnd[DATA_W-1];
				flag_write = 1'b1;
			end
			CSU_RIGHT_ONE:
			begin
				result = {1'b0, opnd[DATA_W-1:1]};
				flag_next = opnd[0];
				flag_write = 1'b1;
			end
			CSU_LEFT_FIXED: result = opnd << fixed_dist_reg;
			CSU_RIGHT_FIXED: result = opnd >> fixed_dist_reg;
			CSU_DYNAMIC: result = dyn_shift(opnd, cnt);
			default: result = opnd;
		endcase
	end

	// Result write in the single execution state
	assign rf_wr = (state_reg == CSU_EXEC);

	// Single write port: execution result first, outside loads only while idle
	always_comb
	begin
		rf_we = 1'b0;
		rf_waddr = dst_reg;
		rf_wdata = result;
		if (rf_wr)
			rf_we = 1'b1;
		else if (load_en && state_reg == CSU_IDLE)
		begin
			rf_we = 1'b1;
			rf_waddr = load_addr;
			rf_wdata = load_data;
		end
	end

	// Registered reads, hence the read state ahead of execution
	csu_regfile #(
		.DATA_W(DATA_W),
		.ADDR_W(CSU_REG_AW)
	) u_regs (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.rd_a_addr(dst_reg),
		.rd_b_addr(src_reg),
		.rd_a_data(opnd),
		.rd_b_data(cnt),
		.wr_en(rf_we),
		.wr_addr(rf_waddr),
		.wr_data(rf_wdata)
	);

	// Sequencer: latch, read registers, one execution state
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= CSU_IDLE;
			kind_reg <= CSU_NONE;
			fixed_dist_reg <= CSU_DIST_TWO;
			dst_reg <= '0;
			src_reg <= '0;
		end
		else if (ce)
		begin
			case (state_reg)
				CSU_IDLE:
				begin
					if (take && legal)
					begin
						kind_reg <= kind_next;
						fixed_dist_reg <= fixed_dist_next;
						dst_reg <= instr[CSU_DST_POS +: CSU_REG_AW];
						src_reg <= instr[CSU_SRC_POS +: CSU_REG_AW];
						state_reg <= CSU_READ;
					end
				end
				CSU_READ: state_reg <= CSU_EXEC;
				CSU_EXEC: state_reg <= CSU_IDLE;
				default: state_reg <= CSU_IDLE;
			endcase
		end
	end

	// Ready only in idle; dropped while an instruction is in flight
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			instr_ready <= 1'b1;
		else if (ce)
		begin
			if (take && legal) // Refused words leave ready high, else the unit would hang
				instr_ready <= 1'b0;
			else if (state_reg == CSU_EXEC)
				instr_ready <= 1'b1;
		end
	end

	// Refusal pulse for opcodes outside this group
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			instr_illegal <= 1'b0;
		else if (ce)
			instr_illegal <= take && !legal;
	end

	// Condition flag: only the one-bit shifts touch it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			t_flag <= CSU_FLAG_RESET;
		else if (ce && rf_wr && flag_write)
			t_flag <= flag_next;
	end

	// Program counter steps once per completed shift
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			pc <= CSU_PC_RESET;
		else if (ce && rf_wr)
			pc <= pc + CSU_PC_STEP;
	end

	// Write-back mirror so the rest of the core sees each result
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wb_valid <= 1'b0;
			wb_addr <= '0;
			wb_data <= CSU_REG_RESET;
		end
		else if (ce)
		begin
			wb_valid <= rf_wr;
			if (rf_wr)
			begin
				wb_addr <= dst_reg;
				wb_data <= result;
			end
		end
	end
endmodule // csu_shift_unit

`default_nettype wire

// [tb/csu_shift_assertions.sv]
/*
 Port checker for the shift unit.
 Assumes it is bound to csu_shift_unit from the bench top.
*/
`default_nettype none
module csu_shift_assertions
	import csu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic instr_valid,
	input wire logic [CSU_IR_W-1:0] instr,
	input wire logic instr_ready,
	input wire logic instr_illegal,
	input wire logic [CSU_PC_W-1:0] pc,
	input wire logic t_flag,
	input wire logic wb_valid,
	input wire logic [CSU_REG_AW-1:0] wb_addr,
	input wire logic [CSU_DATA_W-1:0] wb_data
);
	logic legal;
	logic take;
	logic [3:0] dst;
	// Decode of the offered word, kept apart from the unit's own decoder
	assign legal = instr[15:12] == CSU_GROUP && (instr[3:0] == CSU_OP_DYNAMIC || instr[7:0] inside
		{8'h00, 8'h01, 8'h21, 8'h08, 8'h18, 8'h28, 8'h09, 8'h19, 8'h29});
	assign take = ce && instr_valid && instr_ready;
	assign dst = instr[11:8];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	busy_after_take_a: assert property (take && legal |=> !instr_ready [*2])
		else $error("ready not held low");
	write_back_a: assert property (take && legal ##1 ce [*2] |=> wb_valid && instr_ready && wb_addr == $past(dst, 3))
		else $error("write back late or wrong");
	pc_step_a: assert property (wb_valid && $past(ce) |-> pc == $past(pc) + CSU_PC_STEP)
		else $error("pc step wrong");
	pc_hold_a: assert property (!wb_valid |-> $stable(pc))
		else $error("pc moved without write");
	flag_hold_a: assert property (!wb_valid |-> $stable(t_flag))
		else $error("flag moved without write");
	refuse_word_a: assert property (take && !legal |=> instr_illegal && !wb_valid)
		else $error("bad word not refused");
	refuse_ready_a: assert property (take && !legal |=> instr_ready)
		else $error("ready lost on refused word");
	illegal_once_a: assert property (instr_illegal && ce |=> !instr_illegal)
		else $error("refusal pulse too long");
	wb_once_a: assert property (wb_valid && ce |=> !wb_valid)
		else $error("write pulse too long");
endmodule // csu_shift_assertions
`default_nettype wire

// [tb/tb.sv]
/*
 Self-checking bench for csu_shift_unit.
 Assumes registers start at zero; the bench fills them through the load
 port and the model tracks every write from reset on.
*/
`default_nettype none
module tb
	import csu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic ill; logic [3:0] a; logic [31:0] d; logic f; logic [31:0] p;} csu_exp_s;
	logic mclk, rst, ce, instr_valid, instr_ready, instr_illegal, t_flag, wb_valid, tm, load_en;
	logic [15:0] instr;
	logic [31:0] pc, wb_data, pcm, load_data;
	logic [3:0] wb_addr, load_addr;
	logic [31:0] rm [16];
	logic [7:0] ops [10] = '{8'h00, 8'h01, 8'h21, 8'h08, 8'h18, 8'h28, 8'h09, 8'h19, 8'h29, 8'h0d};
	int n_mismatch, checks;
	csu_exp_s q[$];
	csu_exp_s e;
	csu_shift_unit dut (.mclk(mclk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
		.load_en(load_en), .load_addr(load_addr), .load_data(load_data),
		.instr_ready(instr_ready), .instr_illegal(instr_illegal), .pc(pc), .t_flag(t_flag),
		.wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data));
	task automatic miss(input string s);
		n_mismatch++;
		$display("MISMATCH %0t %s", $time, s);
	endtask
	task automatic results();
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Offer one word, hold it until taken, then note the expected outcome
	task automatic issue(input logic [15:0] w);
		logic [31:0] v, c, r;
		logic f, ok;
		instr <= w;
		instr_valid <= 1'b1;
		do @(posedge mclk); while (!(instr_ready === 1'b1 && ce === 1'b1));
		instr_valid <= 1'b0;
		v = rm[w[11:8]];
		c = rm[w[7:4]];
		r = v;
		f = tm;
		ok = w[15:12] == CSU_GROUP && (w[3:0] == CSU_OP_DYNAMIC || w[7:0] inside {ops});
		if (ok && w[3:0] == CSU_OP_DYNAMIC)
			r = c[31] ? v >> (6'd32 - {1'b0, c[4:0]}) : v << c[4:0];
		else if (ok)
			case (w[7:0])
				CSU_OP_ARITH_RIGHT_ONE: {r, f} = {v[31], v};
				CSU_OP_LEFT_ONE: {f, r} = {v, 1'b0};
				CSU_OP_RIGHT_ONE: {r, f} = {1'b0, v};
				CSU_OP_LEFT_TWO: r = v << 2;
				CSU_OP_LEFT_EIGHT: r = v << 8;
				CSU_OP_LEFT_SIXTEEN: r = v << 16;
				CSU_OP_RIGHT_TWO: r = v >> 2;
				CSU_OP_RIGHT_EIGHT: r = v >> 8;
				default: r = v >> 16;
			endcase
		if (ok)
		begin
			rm[w[11:8]] = r;
			tm = f;
			pcm = pcm + CSU_PC_STEP;
		end
		q.push_back('{!ok, w[11:8], r, tm, pcm});
		@(posedge mclk);
	endtask
	// Write one register once the unit idles, then track it in the model
	task automatic load(input logic [3:0] a, input logic [31:0] d);
		load_en <= 1'b1;
		load_addr <= a;
		load_data <= d;
		do @(posedge mclk); while (!(instr_ready === 1'b1 && ce === 1'b1));
		load_en <= 1'b0;
		rm[a] = d;
		@(posedge mclk);
	endtask
	// Clock, 100 MHz
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Random stalls exercise the clock enable after reset
	always @(posedge mclk)
		if (!rst)
			ce <= ($urandom % 8) != 0;
	// Pop the oldest note whenever a write or refusal shows; a stalled pulse counts once
	always @(posedge mclk)
		if ((wb_valid === 1'b1 || instr_illegal === 1'b1) && ce === 1'b1)
		begin
			checks++;
			if (q.size() == 0)
				miss("unexpected result");
			else
			begin
				e = q.pop_front();
				if (instr_illegal !== e.ill || wb_valid !== !e.ill)
					miss("wrong result kind");
				if (!e.ill && (wb_addr !== e.a || wb_data !== e.d))
					miss("write back");
				if (t_flag !== e.f)
					miss("flag");
				if (pc !== e.p)
					miss("pc");
			end
		end
	// Hang guard, far beyond the expected run
	initial
	begin
		#100us;
		miss("timeout");
		results();
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'h04a84dc9));
		{rst, ce, instr_valid, instr, tm, pcm} = {1'b1, 1'b0, 1'b0, 16'h0000, 1'b0, 32'h0};
		{load_en, load_addr, load_data} = {1'b0, 4'h0, 32'h0};
		foreach (rm[i])
			rm[i] = CSU_REG_RESET;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		checks++;
		if (pc !== CSU_PC_RESET || t_flag !== CSU_FLAG_RESET || instr_ready !== 1'b1 ||
			wb_valid !== 1'b0 || instr_illegal !== 1'b0)
			miss("reset values");
		// Random register contents, so shifts see real data
		foreach (rm[i])
			load(4'(i), $urandom);
		// Every opcode once, then worked dynamic cases, then a random mix with stray words
		foreach (ops[i])
			issue({CSU_GROUP, 4'($urandom), ops[i][7:4] | 4'($urandom * (ops[i][3:0] == 4'hd)), ops[i][3:0]});
		load(4'h1, 32'hffffffec);
		load(4'h2, 32'h80180000);
		issue(16'h421d);
		load(4'h3, 32'h00000014);
		load(4'h4, 32'hfffff801);
		issue(16'h443d);
		load(4'h5, 32'hffffffe0);
		issue(16'h435d);
		load(4'h6, 32'h7fffffe3);
		issue(16'h426d);
		repeat (300)
			case ($urandom % 12)
				0: issue(16'($urandom));
				1: load(4'($urandom), $urandom);
				2, 3: issue({CSU_GROUP, 4'($urandom), 4'($urandom), CSU_OP_DYNAMIC});
				default: issue({CSU_GROUP, 4'($urandom), ops[$urandom % 10]});
			endcase
		repeat (20) @(posedge mclk);
		checks++;
		if (q.size() != 0)
			miss("results missing");
		results();
	end
endmodule // tb
bind csu_shift_unit csu_shift_assertions chk (.mclk(mclk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
	.instr(instr), .instr_ready(instr_ready), .instr_illegal(instr_illegal), .pc(pc), .t_flag(t_flag),
	.wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data));
`default_nettype wire
